// [flg_regs.svh]
// Register indices, bit positions, reset values and timing of the guard
`ifndef FLG_REGS_SVH
`define FLG_REGS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define FLG_IDX_FLASH_STATUS 10'h1b3
`define FLG_IDX_CTRL_ZERO    10'h1b4
`define FLG_IDX_CTRL_ONE     10'h1b5
`define FLG_ADDR_W           12

// ************************************************************
// Field positions
// ************************************************************
`define FLG_C0_RME   1
`define FLG_C0_STOP  3
`define FLG_C0_SRST  4
`define FLG_C0_AEIE  6
`define FLG_C0_RDIE  7
`define FLG_C1_LOCKD 3
`define FLG_C1_BLK   4
`define FLG_ST_RDYF  0
`define FLG_ST_AERF  1
`define FLG_ST_BSY   7

// ************************************************************
// Widths and reset values
// ************************************************************
`define FLG_BLK_W       4
`define FLG_NUM_DBLK    4
`define FLG_RST_BYTE    8'h00
`define FLG_RST_BLK     4'h0
`define FLG_LOCK_OPEN   1'b1
`define FLG_LOCK_SHUT   1'b0

// ************************************************************
// Timing: stop and wake settle time at a 125 MHz clock
// ************************************************************
`define FLG_CLK_NS       8
`define FLG_STOP_TIME_NS 100
`define FLG_STOP_CYC \
  ((`FLG_STOP_TIME_NS + `FLG_CLK_NS - 1) / `FLG_CLK_NS)

`endif

// [flg_pkg.sv]
// Types shared by the lock and rewrite guard
`default_nettype none
`include "flg_regs.svh"

package flg_pkg;

  // Events reported by the flash sequencer engine
  typedef struct packed {
    logic                  busy;          // Engine busy level
    logic                  program_done;  // Program completed
    logic                  erase_done;    // Block erase completed
    logic                  seq_error;     // Command sequence error
    logic                  suspend_enter; // Erase-suspend entered
    logic                  array_access;  // Array read by the CPU
    logic                  lock_prog;     // Lock-bit program done
    logic                  prog_area;     // Done event in program area
    logic [`FLG_BLK_W-1:0] block;         // Block of the done event
  } flg_evt_t;

  // Program or erase command request
  typedef struct packed {
    logic                  valid;
    logic                  prog_area;
    logic [`FLG_BLK_W-1:0] block;
  } flg_cmd_t;

  // Flash power sequence
  typedef enum logic [3:0] {
    PWR_RUN      = 4'b0001,
    PWR_STOPPING = 4'b0010,
    PWR_STOPPED  = 4'b0100,
    PWR_WAKING   = 4'b1000
  } flg_pwr_t;

endpackage

`default_nettype wire

// [flg_lock_store.sv]
// Stored lock bits of the program area blocks, registered read port
`default_nettype none
`include "flg_regs.svh"

module flg_lock_store #(
  parameter int AW = `FLG_BLK_W
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic          wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic               rd_data
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [(2**AW)-1:0] bits;   // One lock bit per block

  // Only explicit writes change a lock bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bits <= {(2**AW){`FLG_LOCK_OPEN}};
    end else if (wr_en) begin
      bits[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the output glitch free
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `FLG_LOCK_OPEN;
    end else begin
      rd_data <= bits[rd_addr];
    end
  end

endmodule

`default_nettype wire

// [flg_guard.sv]
// Lock-disable, block rewrite-disable and flag logic of the sequencer
//
// Functional notes
// - Access during rewrite raises access-error interrupt
// - Busy to ready raises ready interrupt
// - Control one resets zero, low bits zero
// - Bit 3 is lock-disable
// - Bits 4-7 disable blocks A to D
// - Rewrite mode off clears block bits
// - Lock-disable alters a stored lock bit only through an erase
// - Erase under lock-disable unlocks the block
// - Completion, error or suspend clears lock-disable
// - Mode off, stop, sequence reset clear it
// - Only software sets lock-disable
// - Enabled block accepts program and erase
// - Disabled block rejects silently
// - Commands only in rewrite mode
// - Busy flag zero during operations
// - Sequence reset stops engine, reads zero
//
// Design decision made here: the APB slave port.
`default_nettype none
`include "flg_regs.svh"

module flg_guard
  import flg_pkg::*;
#(
  parameter int STOP_CYC = `FLG_STOP_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`FLG_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire flg_evt_t                 evt,
  input  wire flg_cmd_t                 cmd,
  output logic                          cmd_accept,
  output logic                          cmd_reject,
  output logic                          rewrite_mode_enable,
  output logic                          flash_stop,
  output logic                          sequence_reset,
  output logic                          lock_disable,
  output logic [`FLG_NUM_DBLK-1:0]      block_rewrite_disable,
  output logic                          busy_ready_flag,
  output logic                          access_error_irq,
  output logic                          ready_irq
);

  // ************************************************************
  // Address decode
  // ************************************************************
  // Byte address match of one register index
  function automatic logic flg_hit(input logic [`FLG_ADDR_W-1:0] a,
                                   input logic [9:0] idx);
    flg_hit = (a == {idx, 2'b00});
  endfunction

  wire hit_st = flg_hit(paddr, `FLG_IDX_FLASH_STATUS);
  wire hit_c0 = flg_hit(paddr, `FLG_IDX_CTRL_ZERO);
  wire hit_c1 = flg_hit(paddr, `FLG_IDX_CTRL_ONE);
  wire hit_any = hit_st | hit_c0 | hit_c1;
  wire access  = psel & penable;          // Access phase
  wire setup   = psel & ~penable;         // Setup phase
  wire wr      = access & pwrite & hit_any;
  wire wr_st   = wr & hit_st;             // Status write
  wire wr_c0   = wr & hit_c0;             // Control zero write
  wire wr_c1   = wr & hit_c1;             // Control one write

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // ************************************************************
  // State
  // ************************************************************
  logic     ae_irq_en;     // Access-error interrupt enable
  logic     rdy_irq_en;    // Ready interrupt enable
  logic     access_error_flag;
  logic     ready_irq_flag;
  logic     busy_q;        // Busy of previous cycle
  flg_pwr_t pwr;           // Power sequence state
  flg_pwr_t next_pwr;
  logic [7:0] timer;       // Stop and wake settle count
  flg_cmd_t cmd_q;         // Command waiting for lock read
  logic     lock_rd;       // Stored lock bit of cmd_q block

  // ************************************************************
  // Control zero: mode, stop, sequence reset, enables
  // ************************************************************
  wire next_rme  = wr_c0 ? pwdata[`FLG_C0_RME] : rewrite_mode_enable;
  // Stop can only be set while rewrite mode is being kept on
  wire next_stop = wr_c0 ? (pwdata[`FLG_C0_STOP] & pwdata[`FLG_C0_RME])
                         : flash_stop;
  wire srst_wr   = wr_c0 & pwdata[`FLG_C0_SRST];
  wire stop_rise = next_stop & ~flash_stop;
  wire rme_fall  = ~next_rme & rewrite_mode_enable;

  // Register of mode, stop and interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rewrite_mode_enable <= 1'b0;
      flash_stop          <= 1'b0;
      ae_irq_en           <= 1'b0;
      rdy_irq_en          <= 1'b0;
    end else begin
      rewrite_mode_enable <= next_rme;
      flash_stop          <= next_stop;
      if (wr_c0) begin
        ae_irq_en  <= pwdata[`FLG_C0_AEIE];
        rdy_irq_en <= pwdata[`FLG_C0_RDIE];
      end
    end
  end

  // Reset pulse reaches the engine only in rewrite mode while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sequence_reset <= 1'b0;
    end else begin
      sequence_reset <= srst_wr & rewrite_mode_enable & evt.busy;
    end
  end

  // ************************************************************
  // Control one: lock-disable and block rewrite-disable
  // ************************************************************
  // Any hardware clear condition; these win over a software set
  wire lockd_clr = evt.program_done | evt.erase_done
                 | evt.seq_error | evt.suspend_enter
                 | rme_fall | ~next_rme
                 | stop_rise | srst_wr;
  wire next_lockd = lockd_clr ? 1'b0
                  : wr_c1 ? pwdata[`FLG_C1_LOCKD]
                  : lock_disable;

  // Lock-disable register; no event can set it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_disable <= 1'b0;
    end else begin
      lock_disable <= next_lockd;
    end
  end

  // Per-block disable bits, forced low while rewrite mode is off
  genvar gi;
  generate
    for (gi = 0; gi < `FLG_NUM_DBLK; gi++) begin : g_blk
      wire next_dis = ~next_rme ? 1'b0
                    : wr_c1 ? pwdata[`FLG_C1_BLK + gi]
                    : block_rewrite_disable[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          block_rewrite_disable[gi] <= 1'b0;
        end else begin
          block_rewrite_disable[gi] <= next_dis;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Power sequence: stop and wake are busy periods
  // ************************************************************
  wire timer_done = (timer == 8'h00);

  // Next power state
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      PWR_RUN:      if (flash_stop) next_pwr = PWR_STOPPING;
      PWR_STOPPING: if (timer_done) next_pwr = PWR_STOPPED;
      PWR_STOPPED:  if (!flash_stop) next_pwr = PWR_WAKING;
      PWR_WAKING:   if (timer_done) next_pwr = PWR_RUN;
      default:      next_pwr = PWR_RUN;  // Illegal code recovers
    endcase
  end

  // State and settle timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr   <= PWR_RUN;
      timer <= 8'h00;
    end else begin
      pwr <= next_pwr;
      if (next_pwr != pwr) begin
        timer <= 8'(STOP_CYC - 1);
      end else if (!timer_done) begin
        timer <= timer - 8'h01;
      end
    end
  end

  // ************************************************************
  // Busy/ready status and sticky flags
  // ************************************************************
  wire busy_all = evt.busy
                | (pwr == PWR_STOPPING) | (pwr == PWR_WAKING);
  wire rdy_evt  = busy_q & ~busy_all;
  wire ae_evt   = evt.array_access & busy_all;

  assign busy_ready_flag = ~busy_all;

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q            <= 1'b0;
      ready_irq_flag    <= 1'b0;
      access_error_flag <= 1'b0;
    end else begin
      busy_q <= busy_all;
      if (rdy_evt) begin
        ready_irq_flag <= 1'b1;
      end else if (wr_st && !pwdata[`FLG_ST_RDYF]) begin
        ready_irq_flag <= 1'b0;
      end
      if (ae_evt) begin
        access_error_flag <= 1'b1;
      end else if (wr_st && !pwdata[`FLG_ST_AERF]) begin
        access_error_flag <= 1'b0;
      end
    end
  end

  assign ready_irq        = ready_irq_flag & rdy_irq_en;
  assign access_error_irq = access_error_flag & ae_irq_en;

  // ************************************************************
  // Lock bits: only erase and lock program touch them
  // ************************************************************
  wire unlock_wr = evt.erase_done & evt.prog_area & lock_disable;
  wire lk_wr_en  = unlock_wr | evt.lock_prog;
  wire lk_wr_dat = unlock_wr ? `FLG_LOCK_OPEN : `FLG_LOCK_SHUT;

  flg_lock_store #(
    .AW (`FLG_BLK_W)
  ) i_flg_lock_store (
    .clk     (pclk),
    .rstn    (presetn),
    .wr_en   (lk_wr_en),
    .wr_addr (evt.block),
    .wr_data (lk_wr_dat),
    .rd_addr (cmd.block),
    .rd_data (lock_rd)
  );

  // ************************************************************
  // Command gate: decided one cycle after the lock read
  // ************************************************************
  wire dblk_ok  = (cmd_q.block < `FLG_BLK_W'(`FLG_NUM_DBLK));
  wire dblk_en  = dblk_ok &&
                  !block_rewrite_disable[cmd_q.block[1:0]];
  wire area_ok  = cmd_q.prog_area ? (lock_rd | lock_disable)
                                  : dblk_en;
  wire cmd_ok   = rewrite_mode_enable & ~flash_stop & area_ok;

  // Accept or reject pulse; a rejection raises no error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q      <= '0;
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_q      <= cmd;
      cmd_accept <= cmd_q.valid & cmd_ok;
      cmd_reject <= cmd_q.valid & ~cmd_ok;
    end
  end

  // ************************************************************
  // Read data, captured in the setup phase
  // ************************************************************
  wire [7:0] st_byte = (8'(~busy_all) << `FLG_ST_BSY)
                     | (8'(access_error_flag) << `FLG_ST_AERF)
                     | (8'(ready_irq_flag) << `FLG_ST_RDYF);
  // Sequence reset bit always reads zero
  wire [7:0] c0_byte = (8'(rewrite_mode_enable) << `FLG_C0_RME)
                     | (8'(flash_stop) << `FLG_C0_STOP)
                     | (8'(ae_irq_en) << `FLG_C0_AEIE)
                     | (8'(rdy_irq_en) << `FLG_C0_RDIE);
  // Low three bits unassigned and read zero
  wire [7:0] c1_byte = (8'(block_rewrite_disable) << `FLG_C1_BLK)
                     | (8'(lock_disable) << `FLG_C1_LOCKD);
  wire [7:0] rd_byte = hit_st ? st_byte
                     : hit_c0 ? c0_byte
                     : hit_c1 ? c1_byte
                     : `FLG_RST_BYTE;

  // Capturing early lets the access phase finish at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lockd_auto_clr: assert property (
    (evt.program_done || evt.erase_done || evt.seq_error)
      |=> !lock_disable)
    else $error("lock-disable not cleared by completion");
  a_lockd_mode_off: assert property (
    !rewrite_mode_enable |-> !lock_disable)
    else $error("lock-disable set outside rewrite mode");
  a_lockd_sw_only: assert property (
    $rose(lock_disable) |-> $past(wr_c1 && pwdata[`FLG_C1_LOCKD]))
    else $error("lock-disable set without a write");
  a_blk_mode_off: assert property (
    !rewrite_mode_enable |-> (block_rewrite_disable == `FLG_RST_BLK))
    else $error("block disable kept outside rewrite mode");
  a_c1_low_zero: assert property (
    (setup && hit_c1) |=> (prdata[2:0] == 3'b000))
    else $error("unassigned bits read nonzero");
  a_rdy_flag_set: assert property (
    (busy_all ##1 !busy_all) |=> ready_irq_flag)
    else $error("ready flag missed busy to ready");
  a_ae_flag_set: assert property (
    (evt.array_access && busy_all) |=> access_error_flag
      ##1 (access_error_flag || $past(wr_st)))
    else $error("access error flag not sticky");
  a_irq_gate: assert property (
    access_error_irq == (access_error_flag && ae_irq_en))
    else $error("access error interrupt not gated");
  a_blk_reject: assert property (
    (cmd.valid && !cmd.prog_area && cmd.block == 4'h0
      && block_rewrite_disable[0] && !wr_c1) |-> ##2 cmd_reject)
    else $error("disabled block command not rejected");
  a_mode_gate: assert property (
    (cmd.valid && !rewrite_mode_enable && !wr_c0) |-> ##2 !cmd_accept)
    else $error("command accepted outside rewrite mode");

  c_ready_irq:  cover property (rdy_evt && rdy_irq_en);
  c_accept:     cover property (cmd_accept);
  c_reject:     cover property (cmd_reject);
  c_lockd_set:  cover property ($rose(lock_disable));

endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the flash lock and rewrite guard
`default_nettype none
`include "flg_regs.svh"

module tb_top
  import flg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Addresses, signals and scoreboard queues
  // ************************************************************
  localparam logic [11:0] A_ST  = 12'h6cc;       // Status word
  localparam logic [11:0] A_C0  = 12'h6d0;       // Control zero word
  localparam logic [11:0] A_C1  = 12'h6d4;       // Control one word
  localparam logic [11:0] A_BAD = 12'h6d8;       // Unmapped word
  localparam logic [31:0] ALL   = 32'hffffffff;  // Full compare mask
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        cmd_accept, cmd_reject, rme, fstop, srst, lockd, brdy;
  logic        ae_irq, rd_irq, ca;
  logic [3:0]  blk_dis;
  logic [64:0] re;
  flg_evt_t    evt;
  flg_cmd_t    cmd;
  int          n_mismatch, compares;
  logic [64:0] rq[$];  // Read notes: slverr, mask, value
  logic        cq[$];  // Command notes: accept expected

  // Short stop time keeps the power walk brief
  flg_guard #(.STOP_CYC(2)) i_flg_guard (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .cmd(cmd),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .rewrite_mode_enable(rme), .flash_stop(fstop),
    .sequence_reset(srst), .lock_disable(lockd),
    .block_rewrite_disable(blk_dis), .busy_ready_flag(brdy),
    .access_error_irq(ae_irq), .ready_irq(rd_irq));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Closing report, also reached by a used-up wait
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tmo(input string nm);
    n_mismatch++;
    $display("ERROR %s expected done seen timeout", nm);
    summarize();
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Read with a noted expectation; a zero mask is a dummy read
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic er);
    rq.push_back({er, m, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Command request; held valid gives back-to-back requests
  task automatic send(input logic pa, input logic [3:0] b, input logic acc);
    @(posedge pclk);
    cmd <= '{1'b1, pa, b};
    cq.push_back(acc);
  endtask

  task automatic cmd_idle;
    @(posedge pclk);
    cmd.valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("cmd pending", 32'h0, 32'(cq.size()));
  endtask

  // Engine event pulse with its area and block qualifiers
  task automatic pulse(input int k, input logic pa, input logic [3:0] b);
    @(posedge pclk);
    evt.prog_area <= pa;
    evt.block     <= b;
    case (k)
      0: evt.program_done <= 1'b1;
      1: evt.erase_done <= 1'b1;
      2: evt.seq_error <= 1'b1;
      3: evt.suspend_enter <= 1'b1;
      4: evt.array_access <= 1'b1;
      default: evt.lock_prog <= 1'b1;
    endcase
    @(posedge pclk);
    {evt.program_done, evt.erase_done, evt.seq_error, evt.suspend_enter,
     evt.array_access, evt.lock_prog} <= 6'h00;
    @(negedge pclk);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return brdy;
      1: return srst;
      default: return rd_irq;
    endcase
  endfunction

  // Bounded wait for a level on a design output
  task automatic wait_is(input int k, input logic v, input string nm);
    int n;
    n = 0;
    while (sig(k) !== v && n < 40) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 40) tmo(nm);
    chk(nm, 32'(v), 32'(sig(k)));
  endtask

  // ************************************************************
  // Monitor: takes the oldest note as each result appears
  // ************************************************************
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) chk("read note", 32'h0, 32'h1);
      else begin
        re = rq.pop_front();
        chk("prdata", re[31:0] & re[63:32], prdata & re[63:32]);
        chk("pslverr", 32'(re[64]), 32'(pslverr));
      end
    end
    if (cmd_accept === 1'b1 || cmd_reject === 1'b1) begin
      if (cq.size() == 0) chk("cmd note", 32'h0, 32'h1);
      else begin
        ca = cq.pop_front();
        chk("cmd_accept", 32'(ca), 32'(cmd_accept));
        chk("cmd_reject", 32'(!ca), 32'(cmd_reject));
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    evt = '0;
    cmd = '0;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(27));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and the unmapped word
    rd(A_C1, 32'h0, ALL, 1'b0);
    rd(A_C0, 32'h0, ALL, 1'b0);
    wr(A_BAD, ALL);
    rd(A_BAD, 32'h0, ALL, 1'b1);
    chk("busy_ready_flag", 32'h1, 32'(brdy));
    $display("test reset done");
    // Rewrite mode off: block bits held, commands refused
    wr(A_C1, 32'hf8);
    rd(A_C1, 32'h0, ALL, 1'b0);
    send(1'b0, 4'h0, 1'b0);
    cmd_idle();
    // Rewrite mode on: field layout and random writes
    wr(A_C0, 32'h02);
    wr(A_C1, 32'h00);
    wr(A_C1, 32'hff);
    rd(A_C1, 32'hf8, ALL, 1'b0);
    r = $urandom;
    wr(A_C1, r);
    rd(A_C1, r & 32'hf8, ALL, 1'b0);
    // One block disabled at a time, burst of commands
    for (int b = 0; b < 4; b++) begin
      wr(A_C1, 32'h10 << b);
      @(negedge pclk);
      chk("block_rewrite_disable", 32'h1 << b, 32'(blk_dis));
      for (int i = 0; i < 4; i++)
        send(1'b0, 4'(i), 1'(i != b));
      send(1'b0, 4'h4, 1'b0);
      cmd_idle();
    end
    wr(A_C1, 32'hf0);
    wr(A_C1, 32'h00);
    rd(A_C1, 32'h0, ALL, 1'b0);
    $display("test fields done");
    // Hardware clears of the lock-disable bit
    for (int k = 0; k < 4; k++) begin
      wr(A_C1, 32'h08);
      pulse(k, 1'b0, 4'h0);
      chk("lock_disable", 32'h0, 32'(lockd));
    end
    // Stored lock bits against lock-disable
    pulse(5, 1'b1, 4'h2);
    send(1'b1, 4'h2, 1'b0);
    cmd_idle();
    wr(A_C1, 32'h08);
    send(1'b1, 4'h2, 1'b1);
    cmd_idle();
    wr(A_C1, 32'h00);
    send(1'b1, 4'h2, 1'b0);
    cmd_idle();
    wr(A_C1, 32'h08);
    pulse(1, 1'b1, 4'h2);
    chk("lock_disable", 32'h0, 32'(lockd));
    send(1'b1, 4'h2, 1'b1);
    cmd_idle();
    $display("test lock done");
    // Mode off, stop and sequence reset
    wr(A_C1, 32'hf8);
    wr(A_C0, 32'h00);
    @(negedge pclk);
    chk("lock_disable", 32'h0, 32'(lockd));
    chk("block_rewrite_disable", 32'h0, 32'(blk_dis));
    chk("rewrite_mode_enable", 32'h0, 32'(rme));
    wr(A_C0, 32'h02);
    wr(A_C1, 32'h08);
    wr(A_C0, 32'h0a);
    wait_is(0, 1'b0, "busy_ready_flag");
    chk("flash_stop", 32'h1, 32'(fstop));
    chk("rewrite_mode_enable", 32'h1, 32'(rme));
    chk("lock_disable", 32'h0, 32'(lockd));
    send(1'b0, 4'h1, 1'b0);
    cmd_idle();
    wr(A_C0, 32'h02);
    // Waking is a busy period of its own before ready returns
    wait_is(0, 1'b0, "busy_ready_flag");
    wait_is(0, 1'b1, "busy_ready_flag");
    @(posedge pclk);
    evt.busy <= 1'b1;
    wr(A_C1, 32'h08);
    wr(A_C0, 32'h12);
    wait_is(1, 1'b1, "sequence_reset");
    chk("lock_disable", 32'h0, 32'(lockd));
    rd(A_C0, 32'h02, ALL, 1'b0);
    $display("test clears done");
    // Access-error flag and interrupt
    rd(A_ST, 32'h0, 32'h0, 1'b0);
    wr(A_ST, 32'h00);
    wr(A_C0, 32'h42);
    pulse(4, 1'b0, 4'h0);
    chk("access_error_irq", 32'h1, 32'(ae_irq));
    rd(A_ST, 32'h02, ALL, 1'b0);
    wr(A_ST, 32'h00);
    @(negedge pclk);
    chk("access_error_irq", 32'h0, 32'(ae_irq));
    // Ready flag and interrupt on busy to ready
    rd(A_ST, 32'h0, 32'h0, 1'b0);
    wr(A_ST, 32'h00);
    wr(A_C0, 32'hc2);
    @(posedge pclk);
    evt.busy <= 1'b0;
    wait_is(2, 1'b1, "ready_irq");
    pulse(4, 1'b0, 4'h0);
    chk("access_error_irq", 32'h0, 32'(ae_irq));
    rd(A_ST, 32'h81, ALL, 1'b0);
    wr(A_ST, 32'h00);
    @(negedge pclk);
    chk("ready_irq", 32'h0, 32'(rd_irq));
    $display("test flags done");
    chk("read notes left", 32'h0, 32'(rq.size()));
    summarize();
  end

endmodule

`default_nettype wire
